// ==== rtl/mcuirq_ctrl.sv ====
// How it works
// - memory-write done pulse sets the memory-write request flag
// - memory-write vectors only with flag, global, own enable, stack not full
// - memory-write service clears global enable and memory-write flag
// - each timer has compare A and P flags with own enables
// - timer flags feed a multi-source group, no own vector
// - timer vectors need global, timer enable, group enable, stack not full
// - timer service clears global enable and group flag only
// - serial flag set on byte done, address match or bus time-out
// - serial vectors with global and own enable, stack not full; service clears serial flag and global enable
// - uart flag set by any of six uart conditions
// - uart vectors with enables, stack free; service clears flag and global
// - any flag rising during sleep or idle wakes, enables ignored
// - flag already high before sleep gives no wake from it
// - flags stay set until serviced or cleared by software
// - entry pushes program counter only
// - return-from-irq sets global enable; plain return leaves it
// - group flag set when any of its timer flags becomes set
// - requests during service are still latched
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module mcuirq_ctrl
  import mcuirq_pkg::*;
#(
  parameter int unsigned NUM_TMR = DEF_TMR
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic memw_done_i,
  input wire logic [NUM_TMR-1:0] timer_cmp_a_i,
  input wire logic [NUM_TMR-1:0] timer_cmp_p_i,
  input wire logic sim_byte_done_i,
  input wire logic sim_addr_match_i,
  input wire logic sim_timeout_i,
  input wire logic uart_tx_empty_i,
  input wire logic uart_tx_idle_i,
  input wire logic uart_rx_avail_i,
  input wire logic uart_rx_overrun_i,
  input wire logic uart_addr_det_i,
  input wire logic uart_rx_wake_i,
  input wire logic stack_full_i,
  input wire logic ack_i,
  input wire logic ret_i,
  input wire logic return_from_irq_i,
  input wire logic sleep_i,
  output logic irq_req_o,
  output logic [VEC_W-1:0] vector_o,
  output logic push_pc_o,
  output logic wake_o,
  output logic irq_o
);
  if (NUM_TMR < 1 || NUM_TMR > MAX_TMR) begin : g_bad_num_tmr
    $error("NUM_TMR out of range");
  end

  localparam logic [VEC_W-1:0] VEC_SIM = VEC_MF_BASE + VEC_W'(NUM_TMR);
  localparam logic [VEC_W-1:0] VEC_UART = VEC_SIM + 4'h1;

  function automatic logic [DATA_W-1:0] zext(input logic [NUM_TMR-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    r[NUM_TMR-1:0] = v;
    return r;
  endfunction : zext

  logic global_irq_enable;
  logic memwrite_irq_enable;
  logic serial_module_irq_enable;
  logic uart_irq_enable;
  logic memwrite_irq_flag;
  logic serial_module_irq_flag;
  logic uart_irq_flag;
  logic [NUM_TMR-1:0] timer_cmp_a_enable;
  logic [NUM_TMR-1:0] timer_cmp_p_enable;
  logic [NUM_TMR-1:0] timer_cmp_a_flag;
  logic [NUM_TMR-1:0] timer_cmp_p_flag;
  logic [NUM_TMR-1:0] multi_source_enable;
  logic [NUM_TMR-1:0] multi_source_flag;
  logic [EVT_W-1:0] evt_stat;
  logic [EVT_W-1:0] evt_mask;

  logic next_memw_flag;
  logic next_sim_flag;
  logic next_uart_flag;
  logic [NUM_TMR-1:0] next_tmr_a_flag;
  logic [NUM_TMR-1:0] next_tmr_p_flag;
  logic [NUM_TMR-1:0] next_mf_flag;
  logic [NUM_TMR-1:0] tmr_rise;
  logic [NUM_TMR-1:0] mf_ready;
  logic take;
  logic any_rise;
  logic req_any;
  logic blocked;
  logic [VEC_W-1:0] req_vec;
  logic [EVT_W-1:0] evt_set;

  function automatic logic is_wr(input logic [ADDR_W-1:0] a, input logic w,
                                 input logic [ADDR_W-1:0] ofs);
    return w && (a == ofs);
  endfunction : is_wr

  // an acknowledge counts only against an offered vector
  assign take = ack_i && irq_req_o;

  // next flag values: hardware set wins over any clear
  always_comb begin
    next_memw_flag = memw_done_i | (is_wr(addr_i, wr_i, OFS_FLAGS) ? wdata_i[FLG_MEMW] :
      (memwrite_irq_flag & ~(take && vector_o == VEC_MEMW)));
    next_sim_flag = sim_byte_done_i | sim_addr_match_i | sim_timeout_i |
      (is_wr(addr_i, wr_i, OFS_FLAGS) ? wdata_i[FLG_SIM] :
      (serial_module_irq_flag & ~(take && vector_o == VEC_SIM)));
    next_uart_flag = uart_tx_empty_i | uart_tx_idle_i | uart_rx_avail_i |
      uart_rx_overrun_i | uart_addr_det_i | uart_rx_wake_i |
      (is_wr(addr_i, wr_i, OFS_FLAGS) ? wdata_i[FLG_UART] :
      (uart_irq_flag & ~(take && vector_o == VEC_UART)));
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++) begin : g_tmr
      // per-timer A and P flags; held until software clears
      assign next_tmr_a_flag[g] = timer_cmp_a_i[g] |
        (is_wr(addr_i, wr_i, OFS_TMR_A_FLAG) ? wdata_i[g] : timer_cmp_a_flag[g]);
      assign next_tmr_p_flag[g] = timer_cmp_p_i[g] |
        (is_wr(addr_i, wr_i, OFS_TMR_P_FLAG) ? wdata_i[g] : timer_cmp_p_flag[g]);
      // group flag follows a newly set timer flag
      assign tmr_rise[g] = (next_tmr_a_flag[g] & ~timer_cmp_a_flag[g]) |
        (next_tmr_p_flag[g] & ~timer_cmp_p_flag[g]);
      // service clears only the group flag
      assign next_mf_flag[g] = tmr_rise[g] |
        (is_wr(addr_i, wr_i, OFS_MF_FLAG) ? wdata_i[g] :
        (multi_source_flag[g] & ~(take && vector_o == VEC_MF_BASE + VEC_W'(g))));
      // timer request via group, needs timer and group enables
      assign mf_ready[g] = multi_source_flag[g] & multi_source_enable[g] &
        ((timer_cmp_a_flag[g] & timer_cmp_a_enable[g]) |
        (timer_cmp_p_flag[g] & timer_cmp_p_enable[g]));
    end
  endgenerate

  always_comb begin
    req_any = 1'b0;
    req_vec = VEC_MEMW;
    if (memwrite_irq_flag && memwrite_irq_enable) begin
      req_any = 1'b1;
      req_vec = VEC_MEMW;
    end else if (|mf_ready) begin
      req_any = 1'b1;
      for (int i = NUM_TMR - 1; i >= 0; i--) begin
        if (mf_ready[i]) begin
          req_vec = VEC_MF_BASE + VEC_W'(i);
        end
      end
    end else if (serial_module_irq_flag && serial_module_irq_enable) begin
      req_any = 1'b1;
      req_vec = VEC_SIM;
    end else if (uart_irq_flag && uart_irq_enable) begin
      req_any = 1'b1;
      req_vec = VEC_UART;
    end
  end

  // counted as blocked only when a request has global enable set and the stack is full
  assign blocked = req_any && global_irq_enable && stack_full_i;

  // rising edge of any flag, enables not consulted
  assign any_rise = (next_memw_flag & ~memwrite_irq_flag) |
    (next_sim_flag & ~serial_module_irq_flag) | (next_uart_flag & ~uart_irq_flag) |
    (|tmr_rise) | (|(next_mf_flag & ~multi_source_flag));

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      memwrite_irq_flag <= 1'b0;
      serial_module_irq_flag <= 1'b0;
      uart_irq_flag <= 1'b0;
      timer_cmp_a_flag <= '0;
      timer_cmp_p_flag <= '0;
      multi_source_flag <= '0;
    end else begin
      // flags latch regardless of service state
      memwrite_irq_flag <= next_memw_flag;
      serial_module_irq_flag <= next_sim_flag;
      uart_irq_flag <= next_uart_flag;
      timer_cmp_a_flag <= next_tmr_a_flag;
      timer_cmp_p_flag <= next_tmr_p_flag;
      multi_source_flag <= next_mf_flag;
    end
  end

  // global enable: service clears, return-from-irq sets
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      global_irq_enable <= RST_CTRL[CTRL_GIE];
    end else if (take) begin
      global_irq_enable <= 1'b0;
    end else if (return_from_irq_i) begin
      global_irq_enable <= 1'b1;
    end else if (is_wr(addr_i, wr_i, OFS_CTRL)) begin
      global_irq_enable <= wdata_i[CTRL_GIE];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      memwrite_irq_enable <= RST_CTRL[CTRL_MEMW_EN];
      serial_module_irq_enable <= RST_CTRL[CTRL_SIM_EN];
      uart_irq_enable <= RST_CTRL[CTRL_UART_EN];
      timer_cmp_a_enable <= '0;
      timer_cmp_p_enable <= '0;
      multi_source_enable <= '0;
      evt_mask <= '0;
    end else if (wr_i) begin
      if (addr_i == OFS_CTRL) begin
        memwrite_irq_enable <= wdata_i[CTRL_MEMW_EN];
        serial_module_irq_enable <= wdata_i[CTRL_SIM_EN];
        uart_irq_enable <= wdata_i[CTRL_UART_EN];
      end else if (addr_i == OFS_TMR_A_EN) begin
        timer_cmp_a_enable <= wdata_i[NUM_TMR-1:0];
      end else if (addr_i == OFS_TMR_P_EN) begin
        timer_cmp_p_enable <= wdata_i[NUM_TMR-1:0];
      end else if (addr_i == OFS_MF_EN) begin
        multi_source_enable <= wdata_i[NUM_TMR-1:0];
      end else if (addr_i == OFS_EVT_MASK) begin
        evt_mask <= wdata_i[EVT_W-1:0];
      end
    end
  end

  // offer to the core; withdrawn in the cycle after an acknowledge
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_req_o <= 1'b0;
      vector_o <= VEC_MEMW;
      push_pc_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      // global enable and free stack required
      irq_req_o <= req_any && global_irq_enable && !stack_full_i && !take;
      vector_o <= req_vec;
      // only the program counter is pushed
      push_pc_o <= take;
      // wake on rising flag while asleep
      wake_o <= sleep_i && any_rise;
    end
  end

  assign evt_set = {blocked, sleep_i && any_rise, take};

  // sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_stat <= '0;
      irq_o <= 1'b0;
    end else begin
      evt_stat <= evt_set |
        (evt_stat & ~(is_wr(addr_i, wr_i, OFS_EVT_STAT) ? wdata_i[EVT_W-1:0] : '0));
      irq_o <= |(evt_stat & evt_mask);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= RST_ZERO;
    end else if (!rd_i) begin
      rdata_o <= RST_ZERO;
    end else if (addr_i == OFS_CTRL) begin
      rdata_o <= {4'h0, uart_irq_enable, serial_module_irq_enable,
                  memwrite_irq_enable, global_irq_enable};
    end else if (addr_i == OFS_FLAGS) begin
      rdata_o <= {5'h00, uart_irq_flag, serial_module_irq_flag, memwrite_irq_flag};
    end else if (addr_i == OFS_TMR_A_EN) begin
      rdata_o <= zext(timer_cmp_a_enable);
    end else if (addr_i == OFS_TMR_P_EN) begin
      rdata_o <= zext(timer_cmp_p_enable);
    end else if (addr_i == OFS_TMR_A_FLAG) begin
      rdata_o <= zext(timer_cmp_a_flag);
    end else if (addr_i == OFS_TMR_P_FLAG) begin
      rdata_o <= zext(timer_cmp_p_flag);
    end else if (addr_i == OFS_MF_EN) begin
      rdata_o <= zext(multi_source_enable);
    end else if (addr_i == OFS_MF_FLAG) begin
      rdata_o <= zext(multi_source_flag);
    end else if (addr_i == OFS_EVT_STAT) begin
      rdata_o <= {5'h00, evt_stat};
    end else if (addr_i == OFS_EVT_MASK) begin
      rdata_o <= {5'h00, evt_mask};
    end else begin
      rdata_o <= RST_ZERO;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  a_memw_flag_set: assert property (
    memw_done_i |=> memwrite_irq_flag) else $error("memwrite flag not set");
  a_memw_gate: assert property (
    (irq_req_o && vector_o == VEC_MEMW) |-> $past(memwrite_irq_enable && global_irq_enable
      && !stack_full_i)) else $error("memwrite vector without enables");
  a_take_clears_gie: assert property (
    take |=> !global_irq_enable) else $error("global enable kept on entry");
  a_tmr_flag_kept: assert property (
    (take && timer_cmp_a_flag[0] && !wr_i) |=> timer_cmp_a_flag[0])
    else $error("timer flag cleared by service");
  a_sim_flag_set: assert property (
    sim_timeout_i |=> serial_module_irq_flag) else $error("serial flag not set");
  a_uart_flag_set: assert property (
    uart_rx_wake_i |=> uart_irq_flag) else $error("uart flag not set");
  a_wake_rise: assert property (
    (sleep_i && memw_done_i && !memwrite_irq_flag) |=> wake_o) else $error("no wake");
  a_no_wake_high: assert property (
    wake_o |-> $past(any_rise)) else $error("wake without rising flag");
  a_mf_follows: assert property (
    (timer_cmp_p_i[0] && !timer_cmp_p_flag[0]) |=> multi_source_flag[0])
    else $error("group flag not set");
  a_return_from_irq_sets: assert property (
    (return_from_irq_i && !take) |=> global_irq_enable) else $error("return_from_irq no enable");
  a_ret_keeps_gie: assert property (
    (ret_i && !return_from_irq_i && !take && !wr_i) |=>
      (global_irq_enable == $past(global_irq_enable))) else $error("plain return moved enable");
  a_one_push: assert property (
    push_pc_o |=> !push_pc_o [*2]) else $error("double push");

  c_memw_taken: cover property (take && vector_o == VEC_MEMW);
  c_mf_taken: cover property (take && vector_o == VEC_MF_BASE);
  c_blocked: cover property (blocked ##1 !stack_full_i);
  c_wake: cover property (wake_o);
endmodule : mcuirq_ctrl
`default_nettype wire

// ==== rtl/mcuirq_pkg.sv ====
package mcuirq_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned VEC_W = 4;
  localparam int unsigned MAX_TMR = 8;
  localparam int unsigned DEF_TMR = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_TMR_A_EN = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_TMR_P_EN = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_TMR_A_FLAG = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_TMR_P_FLAG = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_MF_EN = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_MF_FLAG = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 4'h9;

  // control register fields
  localparam int unsigned CTRL_GIE = 0;
  localparam int unsigned CTRL_MEMW_EN = 1;
  localparam int unsigned CTRL_SIM_EN = 2;
  localparam int unsigned CTRL_UART_EN = 3;
  // flag register fields
  localparam int unsigned FLG_MEMW = 0;
  localparam int unsigned FLG_SIM = 1;
  localparam int unsigned FLG_UART = 2;
  // event status / mask fields
  localparam int unsigned EVT_TAKEN = 0;
  localparam int unsigned EVT_WAKE = 1;
  localparam int unsigned EVT_BLOCKED = 2;
  localparam int unsigned EVT_W = 3;

  localparam logic [DATA_W-1:0] RST_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;

  // vector codes: memwrite, then one per multi-source group, then serial, uart
  localparam logic [VEC_W-1:0] VEC_MEMW = 4'h0;
  localparam logic [VEC_W-1:0] VEC_MF_BASE = 4'h1;
endpackage : mcuirq_pkg

// ==== testbench/mcuirq_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcuirq_core_model
  import mcuirq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic irq_req_i,
  input wire logic [VEC_W-1:0] vector_i,
  input wire logic push_pc_i,
  input wire logic [1:0] dly_i,
  output logic ack_o,
  output logic [VEC_W-1:0] vec_o,
  output logic [7:0] n_ack_o,
  output logic [7:0] n_push_o
);
  logic [1:0] wait_cnt;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (ack_o || !irq_req_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt == dly_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      n_ack_o <= 8'h00;
      n_push_o <= 8'h00;
      vec_o <= {VEC_W{1'b0}};
    end else begin
      if (ack_o && irq_req_i) begin
        n_ack_o <= n_ack_o + 8'h01;
        vec_o <= vector_i;
      end
      if (push_pc_i) begin
        n_push_o <= n_push_o + 8'h01;
      end
    end
  end
endmodule : mcuirq_core_model
`default_nettype wire

// ==== testbench/test_mcu_interrupt_source_logic.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_mcu_interrupt_source_logic;
  import mcuirq_pkg::*;
  localparam int NT = 3;
  logic clk_sys_i, rst_b_i, wr_i, rd_i, stack_full_i, ret_i, rfi, sleep_i, sel;
  logic irq_req_o, push_pc_o, wake_o, irq_o, ack;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, d;
  logic [9:0] ev, m;
  logic [NT-1:0] ta, tp, tb_bit;
  logic [VEC_W-1:0] vector_o, vec_m, v;
  logic [1:0] dly;
  logic [7:0] n_ack, n_push;
  int fails, n_tests, n_wake, nb, t;

  mcuirq_ctrl #(.NUM_TMR(NT)) u_mcuirq_ctrl (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .memw_done_i(ev[0]), .timer_cmp_a_i(ta), .timer_cmp_p_i(tp),
    .sim_byte_done_i(ev[1]), .sim_addr_match_i(ev[2]), .sim_timeout_i(ev[3]),
    .uart_tx_empty_i(ev[4]), .uart_tx_idle_i(ev[5]), .uart_rx_avail_i(ev[6]),
    .uart_rx_overrun_i(ev[7]), .uart_addr_det_i(ev[8]), .uart_rx_wake_i(ev[9]),
    .stack_full_i(stack_full_i), .ack_i(ack), .ret_i(ret_i), .return_from_irq_i(rfi),
    .sleep_i(sleep_i), .irq_req_o(irq_req_o), .vector_o(vector_o), .push_pc_o(push_pc_o),
    .wake_o(wake_o), .irq_o(irq_o));
  mcuirq_core_model u_mcuirq_core_model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .irq_req_i(irq_req_o), .vector_i(vector_o), .push_pc_i(push_pc_o), .dly_i(dly),
    .ack_o(ack), .vec_o(vec_m), .n_ack_o(n_ack), .n_push_o(n_push));

  function automatic logic [7:0] exp_flags(input logic [9:0] e);
    logic [7:0] r;
    r = 8'h00;
    r[FLG_MEMW] = e[0];
    r[FLG_SIM] = |e[3:1];
    r[FLG_UART] = |e[9:4];
    return r;
  endfunction : exp_flags
  function automatic logic [7:0] exp_vec(input int k);
    // fixed order: memory write, serial, uart
    return (k == 0) ? 8'(VEC_MEMW) : 8'(VEC_MF_BASE + NT + k - 1);
  endfunction : exp_vec
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= x;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] x);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    x = rdata_o;
  endtask : rd
  task automatic pulse(input logic [9:0] e, input logic [NT-1:0] a, input logic [NT-1:0] p);
    @(posedge clk_sys_i);
    ev <= e;
    ta <= a;
    tp <= p;
    @(posedge clk_sys_i);
    ev <= '0;
    ta <= '0;
    tp <= '0;
  endtask : pulse
  task automatic core_pulse(input logic r, input logic f);
    @(posedge clk_sys_i);
    ret_i <= r;
    rfi <= f;
    @(posedge clk_sys_i);
    ret_i <= 1'b0;
    rfi <= 1'b0;
  endtask : core_pulse
  task automatic serve(output logic [VEC_W-1:0] o);
    logic [7:0] n0;
    n0 = n_ack;
    for (int i = 0; i < 30 && n_ack === n0; i++) @(posedge clk_sys_i);
    chk(n_ack, 8'(n0 + 1));
    o = vec_m;
  endtask : serve
  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) if (wake_o === 1'b1) n_wake++;
  // generous bound, whole sequence needs well under 2000 cycles
  initial begin
    #200us;
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h170C));
    {rst_b_i, wr_i, rd_i, stack_full_i, ret_i, rfi, sleep_i} = '0;
    addr_i = '0; wdata_i = '0; ev = '0; ta = '0; tp = '0; dly = 2'h0;
    fails = 0; n_tests = 0; n_wake = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(OFS_CTRL, d); chk(d, RST_CTRL);
    wr(4'hF, 8'hFF); rd(4'hF, d); chk(d, RST_ZERO);
    // single events then random mixes, enables off so flags must hold
    for (int i = 0; i < 16; i++) begin
      m = (i < 10) ? 10'(1 << i) : 10'($urandom);
      pulse(m, '0, '0);
      rd(OFS_FLAGS, d); chk(d, exp_flags(m));
      wr(OFS_FLAGS, 8'h00);
    end
    // wake on rising flag only, enables off
    // memwrite flag set by software before sleep must not wake
    wr(OFS_FLAGS, 8'h01);
    @(posedge clk_sys_i); sleep_i <= 1'b1; nb = n_wake;
    pulse(10'h010, '0, '0); repeat (3) @(posedge clk_sys_i);
    chk(8'(n_wake - nb), 8'h01);
    pulse(10'h041, '0, '0); repeat (3) @(posedge clk_sys_i);
    chk(8'(n_wake - nb), 8'h01);
    @(posedge clk_sys_i); sleep_i <= 1'b0;
    wr(OFS_FLAGS, 8'h00);
    // three sources at once, serviced one by one
    wr(OFS_EVT_STAT, 8'h07); wr(OFS_EVT_MASK, 8'h01); wr(OFS_CTRL, 8'h0F);
    pulse(10'h013, '0, '0);
    for (int k = 0; k < 3; k++) begin
      serve(v); chk(8'(v), exp_vec(k));
      rd(OFS_CTRL, d); chk(d, 8'h0E);
      rd(OFS_FLAGS, d); chk(d, (k == 0) ? 8'h06 : (k == 1) ? 8'h04 : 8'h00);
      chk(n_push, n_ack);
      core_pulse(1'b1, 1'b0);
      rd(OFS_CTRL, d); chk(d, 8'h0E);
      core_pulse(1'b0, 1'b1);
    end
    chk(8'(irq_o), 8'h01);
    wr(OFS_EVT_STAT, 8'h07); repeat (2) @(posedge clk_sys_i);
    chk(8'(irq_o), 8'h00);
    // stack full blocks, then slow core takes it
    @(posedge clk_sys_i); stack_full_i <= 1'b1; dly <= 2'h3;
    pulse(10'h001, '0, '0); repeat (6) @(posedge clk_sys_i);
    chk(8'(irq_req_o), 8'h00);
    rd(OFS_EVT_STAT, d); chk(d, 8'h04);
    @(posedge clk_sys_i); stack_full_i <= 1'b0;
    serve(v); chk(8'(v), 8'(VEC_MEMW));
    dly <= 2'h0;
    // random timer compare sources through their groups
    for (int k = 0; k < 6; k++) begin
      t = $urandom_range(NT - 1);
      sel = 1'($urandom_range(1));
      tb_bit = NT'(1 << t);
      wr(OFS_TMR_A_EN, sel ? 8'h00 : 8'(tb_bit));
      wr(OFS_TMR_P_EN, sel ? 8'(tb_bit) : 8'h00);
      wr(OFS_MF_EN, 8'(tb_bit)); wr(OFS_CTRL, 8'h01);
      pulse('0, sel ? '0 : tb_bit, sel ? tb_bit : '0);
      rd(OFS_MF_FLAG, d); chk(d, 8'(tb_bit));
      serve(v); chk(8'(v), 8'(VEC_MF_BASE + t));
      rd(OFS_MF_FLAG, d); chk(d, 8'h00);
      rd(sel ? OFS_TMR_P_FLAG : OFS_TMR_A_FLAG, d); chk(d, 8'(tb_bit));
      wr(OFS_TMR_A_FLAG, 8'h00); wr(OFS_TMR_P_FLAG, 8'h00);
    end
    wrap_up();
  end
endmodule : test_mcu_interrupt_source_logic
`default_nettype wire
